// ===== adcc_pkg.sv
`default_nettype none
package adcc_pkg;
    localparam int SAMPLE_BITS = 12;
    localparam int INPUT_BITS  = 14;
    localparam int CLK_PERIOD_NS    = 20;
    localparam int SAMPLE_PERIOD_NS = 100;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] REG_STATUS     = 8'h00;
    localparam logic [7:0] REG_REF_LEVEL  = 8'h04;
    localparam logic [7:0] REG_CAL_CYCLES = 8'h08;
    localparam logic [7:0] REG_SAMPLE     = 8'h0C;
    localparam logic [7:0] REG_CONV_COUNT = 8'h10;
    localparam int ST_READY_BIT = 0;
    localparam int ST_CAL_BIT   = 1;
    localparam int ST_PD_BIT    = 2;
    localparam int ST_OR_BIT    = 3;
    localparam int ST_ARMED_BIT = 4;
    localparam logic [11:0] REF_LEVEL_RESET  = 12'hFFF;
    localparam logic [15:0] CAL_CYCLES_RESET = 16'h0400;
    typedef enum logic [2:0] {
        ADCC_RUN   = 3'b001,
        ADCC_CAL   = 3'b010,
        ADCC_PDOWN = 3'b100
    } adcc_state_t;
endpackage : adcc_pkg
`default_nettype wire

// ===== adcc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin,
    output var  logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // A change counts only once the last two stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule : adcc_pin_sync
`default_nettype wire

// ===== adcc_control_port.sv
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcc_control_port (
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic                                sample_clk,
    input  wire logic                                cal_request,
    input  wire logic                                power_down_request,
    input  wire logic                                output_enable_n,
    input  wire logic signed [adcc_pkg::INPUT_BITS-1:0] analog_input,
    output var  logic [adcc_pkg::SAMPLE_BITS-1:0]    sample_word,
    output var  logic                                sample_word_oe,
    output var  logic                                over_range,
    output var  logic                                ready,
    input  wire logic                                hsel,
    input  wire logic [31:0]                         haddr,
    input  wire logic [1:0]                          htrans,
    input  wire logic                                hwrite,
    input  wire logic [2:0]                          hsize,
    input  wire logic [31:0]                         hwdata,
    input  wire logic                                hready,
    output var  logic [31:0]                         hrdata,
    output var  logic                                hreadyout,
    output var  logic                                hresp
);
    import adcc_pkg::*;

    // Over-range test, shared by the datapath and its check
    function automatic logic out_of_range(
        input logic signed [INPUT_BITS-1:0] value,
        input logic [SAMPLE_BITS-1:0]       ref_level
    );
        logic signed [INPUT_BITS-1:0] ref_ext;
        ref_ext = signed'({2'b00, ref_level});
        return (value < 0) || (value > ref_ext);
    endfunction : out_of_range

    // Out-of-range inputs saturate at zero or at the reference
    function automatic logic [SAMPLE_BITS-1:0] clamp_code(
        input logic signed [INPUT_BITS-1:0] value,
        input logic [SAMPLE_BITS-1:0]       ref_level
    );
        logic signed [INPUT_BITS-1:0] ref_ext;
        ref_ext = signed'({2'b00, ref_level});
        if (value < 0) begin
            return '0;
        end else if (value > ref_ext) begin
            return ref_level;
        end
        return value[SAMPLE_BITS-1:0];
    endfunction : clamp_code

    // Pins from outside the clock domain
    logic [3:0] pins_level;
    adcc_pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   ({output_enable_n, power_down_request, cal_request,
                 sample_clk}),
        .level (pins_level)
    );
    logic smp_lvl;
    logic cal_lvl;
    logic pd_lvl;
    logic oe_n_lvl;
    assign smp_lvl  = pins_level[0];
    assign cal_lvl  = pins_level[1];
    assign pd_lvl   = pins_level[2];
    assign oe_n_lvl = pins_level[3];

    // Register file
    logic [SAMPLE_BITS-1:0] ref_level;
    logic [15:0]            cal_cycles;
    logic [15:0]            conv_count;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [SAMPLE_BITS-1:0] next_ref_level;
    logic [15:0]            next_cal_cycles;
    logic                   next_wr_pend;
    logic [7:0]             next_wr_addr;
    logic [31:0]            next_hrdata;

    // Control state
    adcc_state_t state;
    adcc_state_t next_state;
    logic        cal_armed;
    logic        next_cal_armed;
    logic        smp_prev;
    logic        cal_prev;
    logic [15:0] cal_count;
    logic [15:0] next_cal_count;
    logic        next_ready;

    // Datapath
    logic [SAMPLE_BITS-1:0] next_sample_word;
    logic                   next_over_range;
    logic                   next_oe;
    logic [15:0]            next_conv_count;
    logic                   conv_strobe;

    logic addr_phase;
    assign addr_phase = hsel && hready && htrans[1];

    always_comb begin
        next_wr_pend    = addr_phase && hwrite;
        next_wr_addr    = addr_phase ? haddr[7:0] : wr_addr;
        next_ref_level  = ref_level;
        next_cal_cycles = cal_cycles;
        next_hrdata     = hrdata;
        if (wr_pend) begin
            unique case (wr_addr)
                REG_REF_LEVEL:  next_ref_level  = hwdata[SAMPLE_BITS-1:0];
                REG_CAL_CYCLES: next_cal_cycles = hwdata[15:0];
                default: ;
            endcase
        end
        // Read data is fetched in the address phase so it stands
        // from a flop throughout the zero-wait data phase
        if (addr_phase && !hwrite) begin
            next_hrdata = 32'h0000_0000;
            unique case (haddr[7:0])
                REG_STATUS: begin
                    next_hrdata[ST_READY_BIT] = ready;
                    next_hrdata[ST_CAL_BIT]   = (state == ADCC_CAL);
                    next_hrdata[ST_PD_BIT]    = (state == ADCC_PDOWN);
                    next_hrdata[ST_OR_BIT]    = over_range;
                    next_hrdata[ST_ARMED_BIT] = cal_armed;
                end
                REG_REF_LEVEL:  next_hrdata[SAMPLE_BITS-1:0] = ref_level;
                REG_CAL_CYCLES: next_hrdata[15:0] = cal_cycles;
                REG_SAMPLE:     next_hrdata[SAMPLE_BITS-1:0] = sample_word;
                REG_CONV_COUNT: next_hrdata[15:0] = conv_count;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend    <= 1'b0;
            wr_addr    <= 8'h00;
            ref_level  <= REF_LEVEL_RESET;
            cal_cycles <= CAL_CYCLES_RESET;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b0;
            hresp      <= 1'b0;
        end else begin
            wr_pend    <= next_wr_pend;
            wr_addr    <= next_wr_addr;
            ref_level  <= next_ref_level;
            cal_cycles <= next_cal_cycles;
            hrdata     <= next_hrdata;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
    end

    // Sample clock rising edge is the only conversion trigger
    assign conv_strobe = smp_lvl && !smp_prev && (state == ADCC_RUN);

    always_comb begin
        next_state     = state;
        next_cal_count = cal_count;
        // Arm on a rising request, never in power-down
        next_cal_armed = cal_armed;
        if (cal_lvl && !cal_prev) begin
            next_cal_armed = (state != ADCC_PDOWN);
        end
        unique case (state)
            ADCC_RUN: begin
                if (cal_armed && cal_prev && !cal_lvl) begin
                    next_state     = ADCC_CAL;
                    next_cal_count = cal_cycles;
                    next_cal_armed = 1'b0;
                end else if (pd_lvl) begin
                    next_state = ADCC_PDOWN;
                end
            end
            ADCC_CAL: begin
                // Power-down request is looked at only when the count runs out
                if (cal_count <= 16'h0001) begin
                    next_state     = pd_lvl ? ADCC_PDOWN : ADCC_RUN;
                    next_cal_count = 16'h0000;
                end else begin
                    next_cal_count = cal_count - 16'h0001;
                end
            end
            ADCC_PDOWN: begin
                next_cal_armed = 1'b0;
                if (!pd_lvl) begin
                    next_state = ADCC_RUN;
                end
            end
            default: next_state = ADCC_RUN;
        endcase
        next_ready = (next_state == ADCC_RUN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= ADCC_RUN;
            cal_armed <= 1'b0;
            cal_prev  <= 1'b0;
            smp_prev  <= 1'b0;
            cal_count <= 16'h0000;
            ready     <= 1'b0;
        end else begin
            state     <= next_state;
            cal_armed <= next_cal_armed;
            cal_prev  <= cal_lvl;
            smp_prev  <= smp_lvl;
            cal_count <= next_cal_count;
            ready     <= next_ready;
        end
    end

    // The input comes from front-end logic on this clock, so it is
    // captured without synchronisers; one word per strobe
    always_comb begin
        next_sample_word = sample_word;
        next_over_range  = over_range;
        next_conv_count  = conv_count;
        if (conv_strobe) begin
            next_sample_word = clamp_code(analog_input, ref_level);
            next_over_range  = out_of_range(analog_input, ref_level);
            next_conv_count  = conv_count + 16'h0001;
        end
        next_oe = !oe_n_lvl;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_word    <= '0;
            over_range     <= 1'b0;
            conv_count     <= 16'h0000;
            sample_word_oe <= 1'b0;
        end else begin
            sample_word    <= next_sample_word;
            over_range     <= next_over_range;
            conv_count     <= next_conv_count;
            sample_word_oe <= next_oe;
        end
    end

    a_conv_word: assert property (@(posedge clk) disable iff (rst)
        conv_strobe |=> sample_word ==
            clamp_code($past(analog_input), $past(ref_level))
            && conv_count == $past(conv_count) + 16'h0001)
        else $error("conversion word not captured");

    a_conv_paced: assert property (@(posedge clk) disable iff (rst)
        !(smp_lvl && !smp_prev) |=> conv_count == $past(conv_count))
        else $error("conversion without sample clock edge");

    a_cal_start: assert property (@(posedge clk) disable iff (rst)
        (state == ADCC_RUN && cal_armed && cal_prev && !cal_lvl)
            |=> state == ADCC_CAL && !cal_armed)
        else $error("calibration did not start on falling request");

    a_cal_no_arm_pd: assert property (@(posedge clk) disable iff (rst)
        state == ADCC_PDOWN |=> !cal_armed)
        else $error("calibration armed during power-down");

    a_pd_enter: assert property (@(posedge clk) disable iff (rst)
        (state == ADCC_RUN && pd_lvl && !(cal_armed && cal_prev && !cal_lvl))
            |=> state == ADCC_PDOWN)
        else $error("power-down not entered");

    a_pd_in_cal: assert property (@(posedge clk) disable iff (rst)
        (state == ADCC_CAL && cal_count > 16'h0001)
            |=> state == ADCC_CAL)
        else $error("calibration left early");

    // The first edge after reset still shows the reset value, so skip it
    a_oe_follow: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> sample_word_oe == !$past(oe_n_lvl))
        else $error("output enable does not follow pin");

    a_over_range: assert property (@(posedge clk) disable iff (rst)
        conv_strobe |=> over_range ==
            out_of_range($past(analog_input), $past(ref_level)))
        else $error("over-range flag wrong");

    a_ready_state: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> ready == (state == ADCC_RUN))
        else $error("ready does not match state");

    a_word_order: assert property (@(posedge clk) disable iff (rst)
        (conv_strobe && analog_input == 14'sd1 && ref_level != 12'h000)
            |=> sample_word == 12'h001)
        else $error("sample word bit order wrong");
endmodule : adcc_control_port
`default_nettype wire

// ===== adcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_host_model (
    input  wire logic [adcc_pkg::SAMPLE_BITS-1:0] sample_word,
    input  wire logic                             clk,
    input  wire logic                             sample_word_oe,
    input  wire logic                             ready,
    output var  logic                             sample_clk
);
    import adcc_pkg::*;
    logic [SAMPLE_BITS-1:0] last_word;
    initial begin
        sample_clk = 1'b0;
        last_word  = '0;
    end
    // One conversion clock pulse; low between pulses, slow or prompt
    task automatic convert(input int hi, input int lo);
        sample_clk <= 1'b1;
        repeat (hi) @(posedge clk);
        sample_clk <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask : convert
    // Words are kept only while ready and driven; stale ones dropped
    always @(posedge clk) begin
        if (ready === 1'b1 && sample_word_oe === 1'b1) begin
            last_word <= sample_word;
        end
    end
endmodule : adcc_host_model
`default_nettype wire

// ===== adcc_control_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_control_port_tb;
    import adcc_pkg::*;
    logic                         clk = 1'b0;
    logic                         rst = 1'b1;
    logic                         sample_clk, cal_request;
    logic                         power_down_request, output_enable_n;
    logic signed [INPUT_BITS-1:0] analog_input;
    logic [SAMPLE_BITS-1:0]       sample_word;
    logic                         sample_word_oe, over_range, ready;
    logic [31:0]                  haddr, hwdata, hrdata, rd;
    logic [1:0]                   htrans;
    logic                         hwrite, hreadyout, hresp;
    logic [31:0]                  seed = 32'h5540493E;
    int n_errors = 0, checked = 0, exp_word = 0, exp_or = 0, exp_cnt = 0;
    int ref_lvl = 2500, live = 1;
    int vals[$] = '{-8192, -1, 0, 1, 2500, 2501, 8191};

    always #10 clk = ~clk;

    adcc_control_port dut_u (
        .clk(clk), .rst(rst), .sample_clk(sample_clk),
        .cal_request(cal_request), .power_down_request(power_down_request),
        .output_enable_n(output_enable_n), .analog_input(analog_input),
        .sample_word(sample_word), .sample_word_oe(sample_word_oe),
        .over_range(over_range), .ready(ready), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp)
    );
    adcc_host_model host_u (
        .sample_word(sample_word), .clk(clk), .sample_word_oe(sample_word_oe),
        .ready(ready), .sample_clk(sample_clk)
    );

    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'($signed(seed[13:0]));
    endfunction : xs

    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Single word transfer; returns read data taken at the data phase end
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    task automatic conv(input int v);
        analog_input <= v[INPUT_BITS-1:0];
        @(posedge clk);
        host_u.convert(2, 3);
        repeat (4) @(posedge clk);
        if (live != 0) begin
            exp_word = (v < 0) ? 0 : (v > ref_lvl) ? ref_lvl : v;
            exp_or   = (v < 0 || v > ref_lvl) ? 1 : 0;
            exp_cnt++;
        end
        chk("sample_word", sample_word, exp_word);
        chk("over_range", over_range, exp_or);
        ahb(1'b0, REG_CONV_COUNT, 0, rd);
        chk("conv_count", rd, exp_cnt);
    endtask : conv

    task automatic pins(input logic c, p, o);
        cal_request        <= c;
        power_down_request <= p;
        output_enable_n    <= o;
        repeat (8) @(posedge clk);
    endtask : pins

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        {cal_request, power_down_request, output_enable_n} = 3'b000;
        analog_input = '0;
        haddr = '0;
        hwdata = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        repeat (10) @(posedge clk);
        chk("ready_in_reset", ready, 0);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("oe_low_drives", sample_word_oe, 1);
        ahb(1'b0, REG_REF_LEVEL, 0, rd);
        chk("ref_reset", rd, 32'h00000FFF);
        ahb(1'b0, REG_CAL_CYCLES, 0, rd);
        chk("cal_reset", rd, 32'h00000400);
        ahb(1'b0, REG_STATUS, 0, rd);
        chk("status_reset", rd, 32'h00000001);
        ahb(1'b1, REG_REF_LEVEL, ref_lvl, rd);
        ahb(1'b1, REG_CAL_CYCLES, 32'h00000064, rd);
        ahb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
        ahb(1'b0, 8'h40, 0, rd);
        chk("unmapped", rd, 32'h00000000);
        chk("hresp_okay", hresp, 0);
        $display("test registers done");
        foreach (vals[i]) conv(vals[i]);
        repeat (8) conv(xs());
        analog_input <= 14'sh03E8;
        @(posedge clk);
        repeat (8) host_u.convert(2, 3);
        repeat (6) @(posedge clk);
        exp_cnt += 8;
        exp_word = 1000;
        exp_or   = 0;
        ahb(1'b0, REG_CONV_COUNT, 0, rd);
        chk("burst_count", rd, exp_cnt);
        chk("burst_word", sample_word, exp_word);
        chk("burst_or", over_range, exp_or);
        $display("test conversions done");
        pins(1'b0, 1'b0, 1'b1);
        chk("oe_high_release", sample_word_oe, 0);
        pins(1'b0, 1'b0, 1'b0);
        chk("oe_low_drive", sample_word_oe, 1);
        $display("test output enable done");
        pins(1'b1, 1'b0, 1'b0);
        chk("ready_while_req", ready, 1);
        pins(1'b0, 1'b0, 1'b0);
        chk("ready_in_cal", ready, 0);
        live = 0;
        pins(1'b0, 1'b1, 1'b0);
        ahb(1'b0, REG_STATUS, 0, rd);
        chk("pd_ignored_cal", rd, 32'h00000002);
        power_down_request <= 1'b0;
        conv(-5);
        for (int i = 0; i < 150 && ready !== 1'b1; i++) @(posedge clk);
        chk("ready_after_cal", ready, 1);
        chk("host_word", host_u.last_word, exp_word);
        live = 1;
        $display("test calibration done");
        pins(1'b0, 1'b1, 1'b0);
        chk("ready_in_pd", ready, 0);
        live = 0;
        conv(77);
        pins(1'b1, 1'b1, 1'b0);
        pins(1'b0, 1'b1, 1'b0);
        live = 1;
        pins(1'b0, 1'b0, 1'b0);
        repeat (20) @(posedge clk);
        ahb(1'b0, REG_STATUS, 0, rd);
        chk("no_cal_from_pd", rd, 32'h00000001);
        $display("test power down done");
        report_and_stop();
    end
endmodule : adcc_control_port_tb
`default_nettype wire
